//--- verilog/mmr_pkg.sv
`default_nettype none
// Shared constants for the motor measurement readback bank.
package mmr_pkg;
  // Bus data and address widths.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 16;
  // Printed register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CUR_B = 12'h442;
  localparam logic [11:0] IDX_CUR_C = 12'h444;
  localparam logic [11:0] IDX_GAIN = 12'h468;
  localparam logic [11:0] IDX_RANGE = 12'h472;
  localparam logic [11:0] IDX_SUPPLY = 12'h474;
  localparam logic [11:0] IDX_VA = 12'h47a;
  localparam logic [11:0] IDX_VB = 12'h47c;
  // Control and status word of this block.
  localparam logic [11:0] IDX_CTRL = 12'h480;
  // Byte addresses derived from the indices.
  localparam logic [15:0] ADDR_CUR_B = {2'h0, IDX_CUR_B, 2'h0};
  localparam logic [15:0] ADDR_CUR_C = {2'h0, IDX_CUR_C, 2'h0};
  localparam logic [15:0] ADDR_GAIN = {2'h0, IDX_GAIN, 2'h0};
  localparam logic [15:0] ADDR_RANGE = {2'h0, IDX_RANGE, 2'h0};
  localparam logic [15:0] ADDR_SUPPLY = {2'h0, IDX_SUPPLY, 2'h0};
  localparam logic [15:0] ADDR_VA = {2'h0, IDX_VA, 2'h0};
  localparam logic [15:0] ADDR_VB = {2'h0, IDX_VB, 2'h0};
  localparam logic [15:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  // Reset values of every readback word.
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [15:0] RST_HALF = 16'h0;
  // Fixed-point scaling: value over two to this power is the fraction of full scale.
  localparam int unsigned FRAC_BITS = 27;
  // Full-scale volts for the supply and phase voltage words.
  localparam int unsigned VOLT_FULL_SCALE = 60;
  // Current-sense gain codes, as multiples of the peak sense gain.
  localparam logic [1:0] GAIN_X8 = 2'h0;
  localparam logic [1:0] GAIN_X4 = 2'h1;
  localparam logic [1:0] GAIN_X2 = 2'h2;
  localparam logic [1:0] GAIN_X1 = 2'h3;
  // Voltage range codes.
  localparam logic [1:0] RANGE_60V = 2'h0;
  localparam logic [1:0] RANGE_30V = 2'h1;
  localparam logic [1:0] RANGE_15V = 2'h2;
  // Control word fields.
  localparam int unsigned CTRL_FREEZE_BIT = 0;
  localparam int unsigned CTRL_SPEED_DETECT_BIT = 1;
  localparam logic CTRL_FREEZE_RST = 1'b0;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mmr_pkg
`default_nettype wire

//--- verilog/mmr_meas_if.sv
`timescale 1ns/100ps
`default_nettype none
// Carries the captured readback words from the capture stage to the bus side.
interface mmr_meas_if;
  // Captured measurement words.
  logic [31:0] cur_b;
  logic [31:0] cur_c;
  logic [15:0] sense_gain;
  logic [15:0] volt_range;
  logic [31:0] supply;
  logic [31:0] va;
  logic [31:0] vb;
  // Software hold request that stops all updates.
  logic frozen;
  // The capture stage owns the words.
  modport capture (
    output cur_b, cur_c, sense_gain, volt_range, supply, va, vb,
    input frozen
  );
  // The bus side reads the words and owns the hold request.
  modport bus (
    input cur_b, cur_c, sense_gain, volt_range, supply, va, vb,
    output frozen
  );
endinterface : mmr_meas_if
`default_nettype wire

//--- verilog/mmr_capture.sv
`timescale 1ns/100ps
`default_nettype none
// Holds the readback words and loads them from the measurement logic only.
module mmr_capture (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Phase currents with their update strobe.
  input wire logic [31:0] cur_b_in,
  input wire logic [31:0] cur_c_in,
  input wire logic cur_valid,
  // Active gain and range codes, as levels.
  input wire logic [1:0] gain_in,
  input wire logic [1:0] range_in,
  // Supply voltage with its update strobe.
  input wire logic [31:0] supply_in,
  input wire logic supply_valid,
  // Phase voltages, taken only in the speed-detection phase.
  input wire logic [31:0] va_in,
  input wire logic [31:0] vb_in,
  input wire logic volt_valid,
  input wire logic speed_detect,
  // Words towards the bus side.
  mmr_meas_if.capture meas
);
  // All state of the capture stage.
  typedef struct packed {
    logic [31:0] cur_b;
    logic [31:0] cur_c;
    logic [15:0] gain;
    logic [15:0] range;
    logic [31:0] supply;
    logic [31:0] va;
    logic [31:0] vb;
  } mmr_cap_state_t;

  localparam mmr_cap_state_t CAP_RST = '{
    mmr_pkg::RST_WORD, mmr_pkg::RST_WORD, mmr_pkg::RST_HALF, mmr_pkg::RST_HALF,
    mmr_pkg::RST_WORD, mmr_pkg::RST_WORD, mmr_pkg::RST_WORD};

  mmr_cap_state_t st_reg;
  mmr_cap_state_t st_next;

  // Next-state logic; a hold keeps a coherent set for software to read.
  always_comb begin
    st_next = st_reg;
    if (!meas.frozen) begin
      if (cur_valid) begin
        st_next.cur_b = cur_b_in;
      end
      if (cur_valid) begin
        st_next.cur_c = cur_c_in;
      end
      st_next.gain = {14'h0, gain_in};
      if (range_in != 2'h3) begin
        st_next.range = {14'h0, range_in};
      end
      if (supply_valid) begin
        st_next.supply = supply_in;
      end
      if (volt_valid && speed_detect) begin
        st_next.va = va_in;
      end
      if (volt_valid && speed_detect) begin
        st_next.vb = vb_in;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= CAP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign meas.cur_b = st_reg.cur_b;
  assign meas.cur_c = st_reg.cur_c;
  assign meas.sense_gain = st_reg.gain;
  assign meas.volt_range = st_reg.range;
  assign meas.supply = st_reg.supply;
  assign meas.va = st_reg.va;
  assign meas.vb = st_reg.vb;
endmodule : mmr_capture
`default_nettype wire

//--- verilog/mmr_readback.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Phase B current word, 27 fraction bits.
// - Phase C current word, same scaling.
// - Sense gain code zero to three.
// - Voltage range code: 60, 30, 15 V.
// - Supply voltage word against 60 V.
// - Phase A voltage caught in speed detection.
// - Phase B voltage caught in speed detection.
module mmr_readback (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // AXI4-Lite write address channel.
  input wire logic [15:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data channel.
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address channel.
  input wire logic [15:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Measured phase currents and their strobe.
  input wire logic [31:0] MEAS_CURRENT_B,
  input wire logic [31:0] MEAS_CURRENT_C,
  input wire logic MEAS_CURRENT_VALID,
  // Active gain and range codes.
  input wire logic [1:0] MEAS_SENSE_GAIN,
  input wire logic [1:0] MEAS_VOLT_RANGE,
  // Supply voltage and its strobe.
  input wire logic [31:0] MEAS_SUPPLY_VOLTAGE,
  input wire logic MEAS_SUPPLY_VALID,
  // Phase voltages, their strobe and the speed-detection phase flag.
  input wire logic [31:0] MEAS_PHASE_A_VOLTAGE,
  input wire logic [31:0] MEAS_PHASE_B_VOLTAGE,
  input wire logic MEAS_PHASE_VOLT_VALID,
  input wire logic SPEED_DETECT_ACTIVE,
  // Software hold indication.
  output logic READBACK_FROZEN
);
  // Register targets known to the decoder.
  typedef enum logic [3:0] {
    SEL_NONE, SEL_CUR_B, SEL_CUR_C, SEL_GAIN, SEL_RANGE,
    SEL_SUPPLY, SEL_VA, SEL_VB, SEL_CTRL
  } mmr_sel_t;

  // Write channel phases.
  typedef enum logic {WR_COLLECT, WR_RESP} mmr_wr_t;

  // Read channel phases.
  typedef enum logic {RD_ADDR, RD_DATA} mmr_rd_t;

  // All state of the bus side.
  typedef struct packed {
    mmr_wr_t wr;
    mmr_rd_t rd;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic freeze;
  } mmr_bus_state_t;

  // Ready signals start low and rise one cycle after reset.
  localparam mmr_bus_state_t BUS_RST = '{
    WR_COLLECT, RD_ADDR, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0, 32'h0, 4'h0,
    1'b0, mmr_pkg::RESP_OKAY, 1'b0, 1'b0, mmr_pkg::RST_WORD,
    mmr_pkg::RESP_OKAY, mmr_pkg::CTRL_FREEZE_RST};

  mmr_bus_state_t st_reg;
  mmr_bus_state_t st_next;

  // Captured words shared with the capture stage.
  mmr_meas_if meas_if ();

  // Maps a byte address to a register; used by both channels.
  function automatic mmr_sel_t decode(input logic [15:0] addr);
    mmr_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      mmr_pkg::ADDR_CUR_B: sel = SEL_CUR_B;
      mmr_pkg::ADDR_CUR_C: sel = SEL_CUR_C;
      mmr_pkg::ADDR_GAIN: sel = SEL_GAIN;
      mmr_pkg::ADDR_RANGE: sel = SEL_RANGE;
      mmr_pkg::ADDR_SUPPLY: sel = SEL_SUPPLY;
      mmr_pkg::ADDR_VA: sel = SEL_VA;
      mmr_pkg::ADDR_VB: sel = SEL_VB;
      mmr_pkg::ADDR_CTRL: sel = SEL_CTRL;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Capture stage holding the readback words.
  mmr_capture u_capture (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .cur_b_in(MEAS_CURRENT_B),
    .cur_c_in(MEAS_CURRENT_C),
    .cur_valid(MEAS_CURRENT_VALID),
    .gain_in(MEAS_SENSE_GAIN),
    .range_in(MEAS_VOLT_RANGE),
    .supply_in(MEAS_SUPPLY_VOLTAGE),
    .supply_valid(MEAS_SUPPLY_VALID),
    .va_in(MEAS_PHASE_A_VOLTAGE),
    .vb_in(MEAS_PHASE_B_VOLTAGE),
    .volt_valid(MEAS_PHASE_VOLT_VALID),
    .speed_detect(SPEED_DETECT_ACTIVE),
    .meas(meas_if.capture)
  );

  // The hold bit comes straight from the control word.
  assign meas_if.frozen = st_reg.freeze;

  // Next-state logic for both channels.
  always_comb begin
    mmr_sel_t wsel;
    mmr_sel_t rsel;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    st_next = st_reg;
    // Write side: address and data are taken in either order.
    case (st_reg.wr)
      WR_COLLECT: begin
        if (S_AXI_AWVALID && st_reg.awready) begin
          st_next.aw_have = 1'b1;
          st_next.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st_reg.wready) begin
          st_next.w_have = 1'b1;
          st_next.wdata = S_AXI_WDATA;
          st_next.wstrb = S_AXI_WSTRB;
        end
        if (st_next.aw_have && st_next.w_have) begin
          wsel = decode(st_next.awaddr);
          if (wsel == SEL_CTRL && st_next.wstrb[0]) begin
            st_next.freeze = st_next.wdata[mmr_pkg::CTRL_FREEZE_BIT];
          end
          // Only an unmapped address is refused; readback writes answer OKAY.
          if (wsel == SEL_NONE) begin
            st_next.bresp = mmr_pkg::RESP_SLVERR;
          end else begin
            st_next.bresp = mmr_pkg::RESP_OKAY;
          end
          st_next.bvalid = 1'b1;
          st_next.aw_have = 1'b0;
          st_next.w_have = 1'b0;
          st_next.awready = 1'b0;
          st_next.wready = 1'b0;
          st_next.wr = WR_RESP;
        end else begin
          // Each channel stays ready until its own item is held.
          st_next.awready = !st_next.aw_have;
          st_next.wready = !st_next.w_have;
        end
      end
      WR_RESP: begin
        if (S_AXI_BREADY) begin
          st_next.bvalid = 1'b0;
          st_next.awready = 1'b1;
          st_next.wready = 1'b1;
          st_next.wr = WR_COLLECT;
        end
      end
      default: begin
        st_next.wr = WR_COLLECT;
      end
    endcase
    // Read side: one read at a time, data a cycle after the address.
    case (st_reg.rd)
      RD_ADDR: begin
        st_next.arready = 1'b1;
        if (S_AXI_ARVALID && st_reg.arready) begin
          rsel = decode(S_AXI_ARADDR);
          st_next.rresp = mmr_pkg::RESP_OKAY;
          case (rsel)
            SEL_CUR_B: st_next.rdata = meas_if.cur_b;
            SEL_CUR_C: st_next.rdata = meas_if.cur_c;
            SEL_GAIN: st_next.rdata = {16'h0, meas_if.sense_gain};
            SEL_RANGE: st_next.rdata = {16'h0, meas_if.volt_range};
            SEL_SUPPLY: st_next.rdata = meas_if.supply;
            SEL_VA: st_next.rdata = meas_if.va;
            SEL_VB: st_next.rdata = meas_if.vb;
            SEL_CTRL: st_next.rdata = {30'h0, SPEED_DETECT_ACTIVE, st_reg.freeze};
            default: begin
              st_next.rdata = 32'h0;
              st_next.rresp = mmr_pkg::RESP_SLVERR;
            end
          endcase
          st_next.rvalid = 1'b1;
          st_next.arready = 1'b0;
          st_next.rd = RD_DATA;
        end
      end
      RD_DATA: begin
        if (S_AXI_RREADY) begin
          st_next.rvalid = 1'b0;
          st_next.arready = 1'b1;
          st_next.rd = RD_ADDR;
        end
      end
      default: begin
        st_next.rd = RD_ADDR;
      end
    endcase
  end

  // State register.
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      st_reg <= BUS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign S_AXI_AWREADY = st_reg.awready;
  assign S_AXI_WREADY = st_reg.wready;
  assign S_AXI_BRESP = st_reg.bresp;
  assign S_AXI_BVALID = st_reg.bvalid;
  assign S_AXI_ARREADY = st_reg.arready;
  assign S_AXI_RDATA = st_reg.rdata;
  assign S_AXI_RRESP = st_reg.rresp;
  assign S_AXI_RVALID = st_reg.rvalid;
  assign READBACK_FROZEN = st_reg.freeze;

  // Checks below share one clock and the reset.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  // A live current update: the strobe high in this cycle while not frozen.
  sequence cur_update_s;
    MEAS_CURRENT_VALID && !READBACK_FROZEN;
  endsequence

  // A read address handshake on a given register.
  sequence rd_take_s(logic [15:0] a);
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == a;
  endsequence

  // Phase B current reaches the readback and the bus.
  cur_b_load_a: assert property (
    cur_update_s |=> meas_if.cur_b == $past(MEAS_CURRENT_B))
    else $error("phase B current not loaded");
  cur_b_read_a: assert property (
    rd_take_s(mmr_pkg::ADDR_CUR_B) |=> S_AXI_RVALID &&
      S_AXI_RDATA == $past(meas_if.cur_b) && S_AXI_RRESP == mmr_pkg::RESP_OKAY)
    else $error("phase B current read wrong");

  // Phase C current follows its strobe.
  cur_c_load_a: assert property (
    cur_update_s |=> meas_if.cur_c == $past(MEAS_CURRENT_C))
    else $error("phase C current not loaded");

  // The phase C word reaches the bus unchanged, in the cycle after its address.
  cur_c_read_a: assert property (
    rd_take_s(mmr_pkg::ADDR_CUR_C) |=> S_AXI_RVALID &&
      S_AXI_RDATA == $past(meas_if.cur_c))
    else $error("phase C current read wrong");

  // Gain code tracks the input and reads with a zero upper half.
  gain_track_a: assert property (
    !READBACK_FROZEN |=> meas_if.sense_gain == {14'h0, $past(MEAS_SENSE_GAIN)})
    else $error("sense gain code wrong");
  gain_read_a: assert property (
    rd_take_s(mmr_pkg::ADDR_GAIN) |=> S_AXI_RDATA[31:2] == 30'h0)
    else $error("sense gain read has stray bits");

  // Range never shows the undefined code.
  range_code_a: assert property (
    meas_if.volt_range <= {14'h0, mmr_pkg::RANGE_15V})
    else $error("voltage range holds undefined code");

  // The undefined range code leaves the last good code in place.
  range_keep_a: assert property (
    MEAS_VOLT_RANGE == 2'h3 |=> $stable(meas_if.volt_range))
    else $error("voltage range moved on undefined code");

  // Supply voltage follows its strobe.
  supply_load_a: assert property (
    MEAS_SUPPLY_VALID && !READBACK_FROZEN |=>
      meas_if.supply == $past(MEAS_SUPPLY_VOLTAGE))
    else $error("supply voltage not loaded");

  // Phase voltages hold outside the speed-detection phase.
  va_hold_a: assert property (
    !SPEED_DETECT_ACTIVE |=> $stable(meas_if.va))
    else $error("phase A voltage changed outside speed detection");

  // Both phase voltages load in speed detection and hold outside it.
  va_capture_a: assert property (
    MEAS_PHASE_VOLT_VALID && SPEED_DETECT_ACTIVE && !READBACK_FROZEN |=>
      meas_if.va == $past(MEAS_PHASE_A_VOLTAGE))
    else $error("phase A voltage not captured");
  vb_hold_a: assert property (
    !SPEED_DETECT_ACTIVE |=> $stable(meas_if.vb))
    else $error("phase B voltage changed outside speed detection");
  vb_capture_a: assert property (
    MEAS_PHASE_VOLT_VALID && SPEED_DETECT_ACTIVE && !READBACK_FROZEN |=>
      meas_if.vb == $past(MEAS_PHASE_B_VOLTAGE))
    else $error("phase B voltage not captured");

  // A write to a readback word answers OKAY and leaves the word alone.
  wr_ignore_a: assert property (
    st_reg.wr == WR_COLLECT && st_next.wr == WR_RESP &&
      st_next.awaddr == mmr_pkg::ADDR_SUPPLY && !MEAS_SUPPLY_VALID |=>
      S_AXI_BVALID && S_AXI_BRESP == mmr_pkg::RESP_OKAY &&
      $stable(meas_if.supply))
    else $error("readback write not ignored");
  frozen_hold_a: assert property (
    READBACK_FROZEN |=> $stable(meas_if.cur_b) [*2])
    else $error("frozen readback changed");
endmodule : mmr_readback
`default_nettype wire

//--- bench/tb_motor_measurement_readback.sv
`timescale 1ns/100ps
`default_nettype none
// Compares two values, counts the check and reports a mismatch at once.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
// Self-checking bench for the readback bank, driven as an AXI4-Lite master.
module tb_motor_measurement_readback;
  // One ordinary case: input codes, a data word and the codes expected back.
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] range;
    logic [31:0] word;
    logic [15:0] exp_gain;
    logic [15:0] exp_range;
  } mmr_row_t;
  // Range code 3 is undefined, so the last row expects the previous range.
  mmr_row_t rows [4] = '{
    '{2'h0, 2'h0, 32'h0800_0000, 16'h0, 16'h0},
    '{2'h1, 2'h1, 32'hf800_0001, 16'h1, 16'h1},
    '{2'h2, 2'h2, 32'h7fff_ffff, 16'h2, 16'h2},
    '{2'h3, 2'h3, 32'h8000_0000, 16'h3, 16'h2}};
  // Readback addresses in the order of the model array.
  logic [15:0] addr_tab [7] = '{mmr_pkg::ADDR_CUR_B, mmr_pkg::ADDR_CUR_C, mmr_pkg::ADDR_GAIN,
    mmr_pkg::ADDR_RANGE, mmr_pkg::ADDR_SUPPLY, mmr_pkg::ADDR_VA, mmr_pkg::ADDR_VB};
  // Expected contents of each readback word.
  logic [31:0] model [7];
  // Clock, reset and bus master signals, all given a value at time zero.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] awaddr = 16'h0;
  logic [15:0] araddr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  // Slave answers.
  logic awready, wready, bvalid, arready, rvalid, frozen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Measurement side inputs.
  logic [31:0] cur_b = 32'h0;
  logic [31:0] cur_c = 32'h0;
  logic [31:0] supply = 32'h0;
  logic [31:0] va = 32'h0;
  logic [31:0] vb = 32'h0;
  logic [1:0] gain = 2'h0;
  logic [1:0] range = 2'h0;
  logic cur_v = 1'b0;
  logic sup_v = 1'b0;
  logic volt_v = 1'b0;
  logic sd = 1'b0;
  // Counters and scratch values.
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] w;

  // The clock toggles every half period of 50 ns.
  always #50 clk = ~clk;

  // Device under test.
  mmr_readback dut (
    .REF_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .MEAS_CURRENT_B(cur_b), .MEAS_CURRENT_C(cur_c), .MEAS_CURRENT_VALID(cur_v),
    .MEAS_SENSE_GAIN(gain), .MEAS_VOLT_RANGE(range),
    .MEAS_SUPPLY_VOLTAGE(supply), .MEAS_SUPPLY_VALID(sup_v),
    .MEAS_PHASE_A_VOLTAGE(va), .MEAS_PHASE_B_VOLTAGE(vb),
    .MEAS_PHASE_VOLT_VALID(volt_v), .SPEED_DETECT_ACTIVE(sd),
    .READBACK_FROZEN(frozen)
  );

  // Write one word; address and data are offered together and each is dropped when taken.
  task automatic wr(input logic [15:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dat;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rsp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  // Read one word; the data and response are taken at the handshake edge.
  task automatic rd(input logic [15:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        dat = rdata;
        rsp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // One-cycle pulse on the chosen measurement strobes.
  task automatic pulse(input logic c, input logic s, input logic v);
    @(posedge clk);
    cur_v <= c;
    sup_v <= s;
    volt_v <= v;
    @(posedge clk);
    cur_v <= 1'b0;
    sup_v <= 1'b0;
    volt_v <= 1'b0;
  endtask : pulse

  // Reads every readback word and compares it with the model.
  task automatic check_all();
    logic [31:0] dat;
    logic [1:0] rsp;
    for (int i = 0; i < 7; i++) begin
      rd(addr_tab[i], dat, rsp);
      `CHK(dat, model[i])
      `CHK(rsp, mmr_pkg::RESP_OKAY)
    end
  endtask : check_all

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      w = rows[i].word;
      @(posedge clk);
      gain <= rows[i].gain;
      range <= rows[i].range;
      cur_b <= w;
      cur_c <= ~w;
      supply <= w ^ 32'h5a5a_5a5a;
      va <= w + 32'h1;
      vb <= w - 32'h1;
      sd <= 1'b1;
      pulse(1'b1, 1'b1, 1'b1);
      model = '{w, ~w, {16'h0, rows[i].exp_gain}, {16'h0, rows[i].exp_range},
        w ^ 32'h5a5a_5a5a, w + 32'h1, w - 32'h1};
      check_all();
    end
    @(posedge clk);
    va <= 32'h1234_5678;
    vb <= 32'h9abc_def0;
    sd <= 1'b0;
    pulse(1'b0, 1'b0, 1'b1);
    check_all();
    for (int i = 0; i < 7; i++) begin
      wr(addr_tab[i], 32'hffff_ffff, r);
      `CHK(r, mmr_pkg::RESP_OKAY)
    end
    check_all();
    // An unmapped place answers with an error and no data.
    rd(16'h1004, d, r);
    `CHK(d, 32'h0)
    `CHK(r, mmr_pkg::RESP_SLVERR)
    wr(16'h1004, 32'h1, r);
    `CHK(r, mmr_pkg::RESP_SLVERR)
    // Freeze holds every word so that a set of reads stays coherent.
    @(posedge clk);
    sd <= 1'b1;
    wr(mmr_pkg::ADDR_CTRL, 32'h1, r);
    `CHK(frozen, 1'b1)
    @(posedge clk);
    cur_b <= 32'h0123_4567;
    cur_c <= 32'h89ab_cdef;
    supply <= 32'h0fed_cba9;
    gain <= 2'h1;
    pulse(1'b1, 1'b1, 1'b0);
    check_all();
    rd(mmr_pkg::ADDR_CTRL, d, r);
    `CHK(d, 32'h3)
    // Releasing the freeze lets the next strobe land.
    wr(mmr_pkg::ADDR_CTRL, 32'h0, r);
    pulse(1'b1, 1'b1, 1'b0);
    model[0] = 32'h0123_4567;
    model[1] = 32'h89ab_cdef;
    model[2] = 32'h1;
    model[4] = 32'h0fed_cba9;
    check_all();
    // A reset in mid-run clears every word.
    @(posedge clk);
    gain <= 2'h0;
    range <= 2'h0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    model = '{default: 32'h0};
    `CHK(frozen, 1'b0)
    check_all();
    end_of_test();
  end
endmodule : tb_motor_measurement_readback
`default_nettype wire
